// ==== hdl/timer16_cc_defines.vh ====
// Purpose: constants of the timer compare/capture/interrupt block
// Assumes: byte-wide register port, 20 MHz clock
// Notes:   addresses are register indices on the byte port
`ifndef TIMER16_CC_DEFINES_VH
`define TIMER16_CC_DEFINES_VH

// ****************************************
// register addresses
// ****************************************
`define ADDR_W          6
`define ADDR_CMP_BASE   6'h00
`define ADDR_CAP_BASE   6'h0C
`define ADDR_MASK       6'h10
`define ADDR_EXT_MASK   6'h11
`define ADDR_FLAGS      6'h12
`define ADDR_EXT_FLAGS  6'h13

// ****************************************
// field positions and reset values
// ****************************************
`define BIT_CAP         5
`define BIT_CMP_A       4
`define BIT_CMP_B       3
`define BIT_OVF         2
`define BIT_EXT_T3_C    1
`define BIT_EXT_T1_C    0
`define MASK_RESET      8'h00
`define WORD_RESET      16'h0000

// ****************************************
// per-source slots inside a timer
// ****************************************
`define SRC_CAP         0
`define SRC_A           1
`define SRC_B           2
`define SRC_OVF         3
`define SRC_C           4
`define SRC_PER_TIMER   5
`define SRC_TOTAL       10

`endif

// ==== hdl/timer16_compare_capture_irq.v ====
// Purpose: compare and capture registers, event flags and interrupt
//          requests of the first and third 16-bit timers
// Assumes: counter, mode decode, prescaler and pin logic live outside;
//          all inputs are synchronous to CLK
// Notes:   sources are numbered timer*5 + {cap, A, B, ovf, C}
//
// Behaviour
// [RULE1] compare registers hold 16 bits, compared to counter each timer tick
// [RULE2] compare writes commit both bytes at once through shared high-byte latch
// [RULE3] capture event loads counter value; first timer may use comparator event
// [RULE4] capture reads are coherent through the shared high-byte latch
// [RULE5] capture register can serve as counter top, chosen by waveform mode
// [RULE6] mask register: capture bit5, A bit4, B bit3, overflow bit2, reset zero
// [RULE7] request raised only when enable, global enable and flag all set
// [RULE8] extended mask: t3 cap5 A4 B3 ovf2 C1, t1 C0
// [RULE9] software writes zero to extended mask bits 7:6
// [RULE10] extended mask unavailable in legacy mode
// [RULE11] first-timer capture flag at bit 5 set on capture event
// [RULE12] in capture-as-top modes, capture flag sets when counter reaches top
// [RULE13] flags clear on vector execution or writing one; zero leaves them
// [RULE14] compare flags set in timer tick after counter equals compare
// [RULE15] forced compare strobes never set compare flags
// [RULE16] overflow flag set by counter overflow event, mode decided upstream
// [RULE17] extended flags: t3 cap5 A4 B3 ovf2 C1, t1 C0
// [RULE18] capture pin ignored while capture register is the top
// [RULE19] write high byte then low commits; low read latches high byte
// [RULE20] vector acknowledge clears matching flag in the same cycle
//
// Implementation choices: the address-and-strobe port and the address map.
`include "timer16_cc_defines.vh"

module timer16_compare_capture_irq (
    input  wire                CLK,
    input  wire                RST,
    input  wire [`ADDR_W-1:0]  ADDR,
    input  wire [7:0]          WDATA,
    input  wire                WR,
    input  wire                RD,
    output reg  [7:0]          RDATA,
    input  wire                LEGACY_MODE,
    input  wire                GLOBAL_IE,
    input  wire [15:0]         COUNT1,
    input  wire [15:0]         COUNT3,
    input  wire                TICK1,
    input  wire                TICK3,
    input  wire [3:0]          WAVE_MODE1,
    input  wire [3:0]          WAVE_MODE3,
    input  wire                CAP_PIN_EVT1,
    input  wire                CAP_PIN_EVT3,
    input  wire                ACOMP_EVT,
    input  wire                ACOMP_SEL,
    input  wire                TOP_EVT1,
    input  wire                TOP_EVT3,
    input  wire                OVF_EVT1,
    input  wire                OVF_EVT3,
    input  wire [2:0]          FORCE1,
    input  wire [2:0]          FORCE3,
    input  wire [9:0]          VEC_ACK,
    output wire [9:0]          IRQ_REQ,
    output reg  [2:0]          MATCH1,
    output reg  [2:0]          MATCH3,
    output wire [15:0]         CMP1_A,
    output wire [15:0]         CMP1_B,
    output wire [15:0]         CMP1_C,
    output wire [15:0]         CMP3_A,
    output wire [15:0]         CMP3_B,
    output wire [15:0]         CMP3_C,
    output wire [15:0]         CAPTURE1,
    output wire [15:0]         CAPTURE3
);

    // ****************************************
    // helpers
    // ****************************************
    // modes 8, 10, 12 and 14 take their top from the capture register
    function cap_is_top;
        input [3:0] mode;
        begin
            cap_is_top = mode[3] & ~mode[0]; // [RULE5]
        end
    endfunction

    function [9:0] pack_flags;
        input [7:0] main_b;
        input [7:0] ext_b;
        begin
            pack_flags = {ext_b[`BIT_EXT_T3_C], ext_b[`BIT_OVF], ext_b[`BIT_CMP_B],
                          ext_b[`BIT_CMP_A], ext_b[`BIT_CAP],
                          ext_b[`BIT_EXT_T1_C], main_b[`BIT_OVF], main_b[`BIT_CMP_B],
                          main_b[`BIT_CMP_A], main_b[`BIT_CAP]};
        end
    endfunction

    // ****************************************
    // storage
    // ****************************************
    reg  [15:0] cmp_r [0:5];
    reg  [15:0] cap_r [0:1];
    reg  [7:0]  temp_r;
    reg  [7:0]  mask_r;
    reg  [5:0]  ext_mask_r;
    reg  [9:0]  flag_r;
    reg  [9:0]  flag_nxt;
    reg  [5:0]  pend_r;
    reg  [5:0]  pend_nxt;
    reg  [7:0]  rdata_nxt;
    reg  [7:0]  temp_nxt;

    wire [15:0] count [0:1];
    wire [1:0]  tick;
    wire [3:0]  mode [0:1];
    wire [1:0]  cap_evt;
    wire [1:0]  top_evt;
    wire [1:0]  ovf_evt;
    wire [9:0]  enables;
    wire [9:0]  w1c;
    wire [5:0]  eq;
    wire        wr_cmp;
    wire        wr_cap;
    wire        rd_cap_lo;
    wire [2:0]  cmp_idx;
    wire        cap_idx;
    wire        ext_ok;

    assign count[0] = COUNT1;
    assign count[1] = COUNT3;
    assign tick     = {TICK3, TICK1};
    assign mode[0]  = WAVE_MODE1;
    assign mode[1]  = WAVE_MODE3;
    assign top_evt  = {TOP_EVT3, TOP_EVT1};
    assign ovf_evt  = {OVF_EVT3, OVF_EVT1};
    assign ext_ok   = ~LEGACY_MODE;

    // the comparator only steers the first timer's capture source
    assign cap_evt[0] = (ACOMP_SEL ? ACOMP_EVT : CAP_PIN_EVT1)
                        & ~cap_is_top(WAVE_MODE1); // [RULE3] [RULE18]
    assign cap_evt[1] = CAP_PIN_EVT3 & ~cap_is_top(WAVE_MODE3); // [RULE18]

    assign CMP1_A   = cmp_r[0];
    assign CMP1_B   = cmp_r[1];
    assign CMP1_C   = cmp_r[2];
    assign CMP3_A   = cmp_r[3];
    assign CMP3_B   = cmp_r[4];
    assign CMP3_C   = cmp_r[5];
    assign CAPTURE1 = cap_r[0];
    assign CAPTURE3 = cap_r[1];

    // ****************************************
    // address decode
    // ****************************************
    assign wr_cmp    = WR & (ADDR < `ADDR_CAP_BASE);
    assign wr_cap    = WR & (ADDR >= `ADDR_CAP_BASE) & (ADDR < `ADDR_MASK);
    assign rd_cap_lo = RD & (ADDR >= `ADDR_CAP_BASE) & (ADDR < `ADDR_MASK) & ~ADDR[0];
    assign cmp_idx   = ADDR[3:1];
    assign cap_idx   = ADDR[1];

    // ****************************************
    // compare detection
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : gen_eq
            assign eq[g] = (count[g / 3] == cmp_r[g]); // [RULE1]
        end
    endgenerate

    // a match seen on one tick becomes the flag on the next tick
    always @* begin
        pend_nxt = pend_r;
        if (tick[0]) begin
            pend_nxt[2:0] = eq[2:0]; // [RULE14]
        end
        if (tick[1]) begin
            pend_nxt[5:3] = eq[5:3]; // [RULE14]
        end
    end

    // ****************************************
    // flags: set wins over any clear
    // ****************************************
    assign w1c = ((WR & (ADDR == `ADDR_FLAGS)) ? pack_flags(WDATA, 8'h00) : 10'h000)
               | ((WR & ext_ok & (ADDR == `ADDR_EXT_FLAGS))
                  ? pack_flags(8'h00, WDATA) : 10'h000);

    always @* begin : flag_logic
        integer t;
        t = 0;
        flag_nxt = flag_r & ~w1c & ~VEC_ACK; // [RULE13] [RULE20]
        for (t = 0; t < 2; t = t + 1) begin
            if (cap_evt[t] | (cap_is_top(mode[t]) & top_evt[t])) begin
                flag_nxt[t*`SRC_PER_TIMER+`SRC_CAP] = 1'b1; // [RULE11] [RULE12]
            end
            if (ovf_evt[t]) begin
                flag_nxt[t*`SRC_PER_TIMER+`SRC_OVF] = 1'b1; // [RULE16]
            end
            // force strobes never reach here, only true matches do
            if (tick[t]) begin
                if (pend_r[t*3]) begin
                    flag_nxt[t*`SRC_PER_TIMER+`SRC_A] = 1'b1; // [RULE14] [RULE15]
                end
                if (pend_r[t*3+1]) begin
                    flag_nxt[t*`SRC_PER_TIMER+`SRC_B] = 1'b1; // [RULE14]
                end
                if (pend_r[t*3+2]) begin
                    flag_nxt[t*`SRC_PER_TIMER+`SRC_C] = 1'b1; // [RULE14]
                end
            end
        end
    end

    assign enables = pack_flags(mask_r, {2'b00, ext_mask_r});
    assign IRQ_REQ = flag_r & enables & {10{GLOBAL_IE}}; // [RULE7]

    // ****************************************
    // read path and shared high-byte latch
    // ****************************************
    always @* begin
        temp_nxt  = temp_r;
        rdata_nxt = 8'h00;
        if (WR & ADDR[0] & (ADDR < `ADDR_MASK)) begin
            temp_nxt = WDATA; // [RULE19]
        end
        if (RD) begin
            if (ADDR < `ADDR_CAP_BASE) begin
                rdata_nxt = ADDR[0] ? cmp_r[cmp_idx][15:8] : cmp_r[cmp_idx][7:0];
            end else if (ADDR < `ADDR_MASK) begin
                // high byte comes from the latch, filled by the low read
                rdata_nxt = ADDR[0] ? temp_r : cap_r[cap_idx][7:0]; // [RULE4]
                if (rd_cap_lo) begin
                    temp_nxt = cap_r[cap_idx][15:8]; // [RULE4] [RULE19]
                end
            end else if (ADDR == `ADDR_MASK) begin
                rdata_nxt = mask_r;
            end else if (ADDR == `ADDR_EXT_MASK) begin
                rdata_nxt = ext_ok ? {2'b00, ext_mask_r} : 8'h00; // [RULE10]
            end else if (ADDR == `ADDR_FLAGS) begin
                rdata_nxt = {2'b00, flag_r[`SRC_CAP], flag_r[`SRC_A], flag_r[`SRC_B],
                             flag_r[`SRC_OVF], 2'b00};
            end else if (ADDR == `ADDR_EXT_FLAGS) begin
                // sources run cap..C upward, the register wants cap at bit 5 down to C
                rdata_nxt = ext_ok ? {2'b00, flag_r[5], flag_r[6], flag_r[7], flag_r[8],
                                      flag_r[9], flag_r[4]} : 8'h00; // [RULE17]
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always @(posedge CLK or posedge RST) begin : regs
        integer i;
        if (RST) begin
            for (i = 0; i < 6; i = i + 1) begin
                cmp_r[i] <= `WORD_RESET;
            end
            cap_r[0]   <= `WORD_RESET;
            cap_r[1]   <= `WORD_RESET;
            temp_r     <= 8'h00;
            mask_r     <= `MASK_RESET;
            ext_mask_r <= 6'h00;
            flag_r     <= 10'h000;
            pend_r     <= 6'h00;
            RDATA      <= 8'h00;
            MATCH1     <= 3'h0;
            MATCH3     <= 3'h0;
        end else begin
            temp_r <= temp_nxt;
            flag_r <= flag_nxt;
            pend_r <= pend_nxt;
            RDATA  <= rdata_nxt;
            // waveform unit sees both true and forced matches
            MATCH1 <= ({3{TICK1}} & eq[2:0]) | FORCE1; // [RULE1] [RULE15]
            MATCH3 <= ({3{TICK3}} & eq[5:3]) | FORCE3;
            if (wr_cmp & ~ADDR[0]) begin
                cmp_r[cmp_idx] <= {temp_r, WDATA}; // [RULE2] [RULE19]
            end
            // a software write to the capture register only makes sense as top
            if (wr_cap & ~ADDR[0] & cap_is_top(mode[cap_idx])) begin
                cap_r[cap_idx] <= {temp_r, WDATA}; // [RULE5]
            end
            for (i = 0; i < 2; i = i + 1) begin
                if (cap_evt[i]) begin
                    cap_r[i] <= count[i]; // [RULE3]
                end
            end
            if (WR & (ADDR == `ADDR_MASK)) begin
                mask_r <= WDATA; // [RULE6]
            end
            if (WR & ext_ok & (ADDR == `ADDR_EXT_MASK)) begin
                ext_mask_r <= WDATA[5:0]; // [RULE8] [RULE9] [RULE10]
            end
        end
    end

endmodule

// ==== tb/timer16_cc_sva.sv ====
// Purpose: port-level assertions for the timer compare/capture block
// Assumes: one clock CLK, RST asynchronous and active high
// Notes:   modes 8,10,12,14 make the capture register the top
`include "timer16_cc_defines.vh"
module timer16_cc_sva (
    input logic        CLK,
    input logic        RST,
    input logic [5:0]  ADDR,
    input logic [7:0]  WDATA,
    input logic        WR,
    input logic        RD,
    input logic [7:0]  RDATA,
    input logic        LEGACY_MODE,
    input logic        GLOBAL_IE,
    input logic [15:0] COUNT1,
    input logic        TICK1,
    input logic [3:0]  WAVE_MODE3,
    input logic [3:0]  WAVE_MODE1,
    input logic        CAP_PIN_EVT1,
    input logic        CAP_PIN_EVT3,
    input logic        ACOMP_SEL,
    input logic        OVF_EVT1,
    input logic [2:0]  FORCE1,
    input logic [9:0]  IRQ_REQ,
    input logic [2:0]  MATCH1,
    input logic [15:0] CMP1_A,
    input logic [15:0] CAPTURE1,
    input logic [15:0] CAPTURE3
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    wire top1 = WAVE_MODE1[3] & ~WAVE_MODE1[0];
    wire top3 = WAVE_MODE3[3] & ~WAVE_MODE3[0];
    irq_gate_a: assert property (|IRQ_REQ |-> GLOBAL_IE)
        else $error("request without global enable");
    match_seen_a: assert property (TICK1 && COUNT1 == CMP1_A |=> MATCH1[0])
        else $error("compare match missed");
    match_cause_a: assert property (MATCH1[0] |-> $past(TICK1 && COUNT1 == CMP1_A || FORCE1[0]))
        else $error("match pulse without cause");
    cap_load_a: assert property (CAP_PIN_EVT1 && !ACOMP_SEL && !top1 |=> CAPTURE1 == $past(COUNT1))
        else $error("capture did not load counter");
    cap_block_a: assert property (CAP_PIN_EVT3 && top3 && !WR |=> $stable(CAPTURE3))
        else $error("capture taken while top");
    cmp_write_a: assert property (WR && ADDR == `ADDR_CMP_BASE |=> CMP1_A[7:0] == $past(WDATA))
        else $error("compare low byte not committed");
    ovf_rise_a: assert property ($rose(IRQ_REQ[3]) |-> $past(OVF_EVT1 || WR || !GLOBAL_IE))
        else $error("overflow request without event");
    legacy_rd_a: assert property (RD && LEGACY_MODE && (ADDR == `ADDR_EXT_MASK
        || ADDR == `ADDR_EXT_FLAGS) |=> RDATA == 8'h00)
        else $error("extended register visible in legacy mode");
    cover property (MATCH1[0]);
    cover property (|IRQ_REQ);
    cover property (CAP_PIN_EVT3 && top3);
endmodule
bind timer16_compare_capture_irq timer16_cc_sva chk (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LEGACY_MODE(LEGACY_MODE),
    .GLOBAL_IE(GLOBAL_IE), .COUNT1(COUNT1), .TICK1(TICK1), .WAVE_MODE3(WAVE_MODE3),
    .WAVE_MODE1(WAVE_MODE1), .CAP_PIN_EVT1(CAP_PIN_EVT1), .CAP_PIN_EVT3(CAP_PIN_EVT3),
    .ACOMP_SEL(ACOMP_SEL), .OVF_EVT1(OVF_EVT1), .FORCE1(FORCE1), .IRQ_REQ(IRQ_REQ),
    .MATCH1(MATCH1), .CMP1_A(CMP1_A), .CAPTURE1(CAPTURE1), .CAPTURE3(CAPTURE3));

// ==== tb/cpu_bus_model.sv ====
// Purpose: processor side of the byte register port
// Assumes: read data stand only in the cycle after the read strobe
// Notes:   one idle cycle between accesses keeps every strobe edge distinct
`include "timer16_cc_defines.vh"
module cpu_bus_model (
    input  logic       CLK,
    input  logic [7:0] RDATA,
    output logic [5:0] ADDR,
    output logic [7:0] WDATA,
    output logic       WR,
    output logic       RD
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ADDR = 6'h00;
        WDATA = 8'h00;
        WR = 1'b0;
        RD = 1'b0;
    end
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= (a == `ADDR_EXT_MASK) ? (d & 8'h3F) : d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask
endmodule

// ==== tb/timer16_compare_capture_irq_bench.sv ====
// Purpose: self-checking bench of the timer compare/capture block
// Assumes: inputs change by non-blocking assignment at rising edges
// Notes:   third timer shares counter and tick with the first
`include "timer16_cc_defines.vh"
module timer16_compare_capture_irq_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 0, RST = 1, LEGACY_MODE = 0, GLOBAL_IE = 0, TICK1 = 0;
    logic CAP_PIN_EVT1 = 0, CAP_PIN_EVT3 = 0, TOP_EVT1 = 0, TOP_EVT3 = 0;
    logic OVF_EVT1 = 0, OVF_EVT3 = 0;
    logic [15:0] COUNT1 = 16'h0000;
    logic [3:0]  WAVE_MODE1 = 4'h0;
    logic [2:0]  FORCE1 = 3'h0;
    logic [9:0]  VEC_ACK = 10'h000;
    wire  [5:0]  ADDR;
    wire  [7:0]  WDATA, RDATA;
    wire         WR, RD;
    wire  [9:0]  IRQ_REQ;
    wire  [15:0] CMP1_A, CAPTURE1, CAPTURE3;
    int failures = 0, n_compared = 0;
    always #25 CLK = ~CLK;
    cpu_bus_model cpu (.CLK(CLK), .RDATA(RDATA), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD));
    // top-as-capture mode on the third timer keeps its pin blocked throughout
    timer16_compare_capture_irq uut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .LEGACY_MODE(LEGACY_MODE), .GLOBAL_IE(GLOBAL_IE),
        .COUNT1(COUNT1), .COUNT3(COUNT1), .TICK1(TICK1), .TICK3(TICK1),
        .WAVE_MODE1(WAVE_MODE1), .WAVE_MODE3(4'h8), .CAP_PIN_EVT1(CAP_PIN_EVT1),
        .CAP_PIN_EVT3(CAP_PIN_EVT3), .ACOMP_EVT(1'b0), .ACOMP_SEL(1'b0), .TOP_EVT1(TOP_EVT1),
        .TOP_EVT3(TOP_EVT3), .OVF_EVT1(OVF_EVT1), .OVF_EVT3(OVF_EVT3), .FORCE1(FORCE1),
        .FORCE3(3'h0), .VEC_ACK(VEC_ACK), .IRQ_REQ(IRQ_REQ), .MATCH1(), .MATCH3(),
        .CMP1_A(CMP1_A), .CMP1_B(), .CMP1_C(), .CMP3_A(), .CMP3_B(), .CMP3_C(),
        .CAPTURE1(CAPTURE1), .CAPTURE3(CAPTURE3));
    // ****************************************
    // helpers
    // ****************************************
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task rdchk(input logic [5:0] a, input logic [7:0] e, input string n);
        logic [7:0] d;
        cpu.rd(a, d);
        chk(n, {8'h00, e}, {8'h00, d});
    endtask
    task tick;
        @(posedge CLK) TICK1 <= 1'b1;
        @(posedge CLK) TICK1 <= 1'b0;
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_masks;
        rdchk(`ADDR_MASK, 8'h00, "mask reset");
        rdchk(`ADDR_EXT_FLAGS, 8'h00, "ext flags reset");
        cpu.wr(`ADDR_MASK, 8'h3C);
        rdchk(`ADDR_MASK, 8'h3C, "mask");
        cpu.wr(`ADDR_EXT_MASK, 8'h3F);
        rdchk(`ADDR_EXT_MASK, 8'h3F, "ext mask");
        @(posedge CLK) LEGACY_MODE <= 1'b1;
        cpu.wr(`ADDR_EXT_MASK, 8'h00);
        rdchk(`ADDR_EXT_MASK, 8'h00, "legacy ext mask");
        @(posedge CLK) LEGACY_MODE <= 1'b0;
        rdchk(`ADDR_EXT_MASK, 8'h3F, "ext mask kept");
        rdchk(6'h20, 8'h00, "unmapped");
    endtask
    task t_compare;
        cpu.wr(`ADDR_CMP_BASE + 6'h01, 8'h12);
        cpu.wr(`ADDR_CMP_BASE, 8'h34);
        #1 chk("compare a", 16'h1234, CMP1_A);
        @(posedge CLK) COUNT1 <= 16'h1234;
        GLOBAL_IE <= 1'b1;
        tick();
        @(posedge CLK) COUNT1 <= 16'h1235;
        tick();
        rdchk(`ADDR_FLAGS, 8'h10, "compare flag");
        chk("irq", 16'h0002, {6'h00, IRQ_REQ});
        cpu.wr(`ADDR_FLAGS, 8'h00);
        rdchk(`ADDR_FLAGS, 8'h10, "flag after zero");
        cpu.wr(`ADDR_FLAGS, 8'h10);
        rdchk(`ADDR_FLAGS, 8'h00, "flag after one");
        @(posedge CLK) FORCE1 <= 3'h7;
        @(posedge CLK) FORCE1 <= 3'h0;
        tick();
        tick();
        rdchk(`ADDR_FLAGS, 8'h00, "forced flags");
        rdchk(`ADDR_EXT_FLAGS, 8'h00, "forced c flag");
    endtask
    task t_capture;
        @(posedge CLK) COUNT1 <= 16'hBEEF;
        CAP_PIN_EVT1 <= 1'b1;
        @(posedge CLK) CAP_PIN_EVT1 <= 1'b0;
        #1 chk("capture", 16'hBEEF, CAPTURE1);
        rdchk(`ADDR_CAP_BASE, 8'hEF, "capture low");
        @(posedge CLK) COUNT1 <= 16'h5555;
        CAP_PIN_EVT1 <= 1'b1;
        @(posedge CLK) CAP_PIN_EVT1 <= 1'b0;
        rdchk(`ADDR_CAP_BASE + 6'h01, 8'hBE, "capture high");
        rdchk(`ADDR_FLAGS, 8'h20, "capture flag");
        @(posedge CLK) VEC_ACK <= 10'h001;
        @(posedge CLK) VEC_ACK <= 10'h000;
        rdchk(`ADDR_FLAGS, 8'h00, "acked flag");
    endtask
    task t_top;
        @(posedge CLK) WAVE_MODE1 <= 4'h8;
        COUNT1 <= 16'h0777;
        @(posedge CLK) CAP_PIN_EVT1 <= 1'b1;
        CAP_PIN_EVT3 <= 1'b1;
        @(posedge CLK) CAP_PIN_EVT1 <= 1'b0;
        CAP_PIN_EVT3 <= 1'b0;
        #1 chk("blocked capture", 16'h5555, CAPTURE1);
        rdchk(`ADDR_EXT_FLAGS, 8'h00, "blocked flag");
        @(posedge CLK) TOP_EVT1 <= 1'b1;
        TOP_EVT3 <= 1'b1;
        @(posedge CLK) TOP_EVT1 <= 1'b0;
        TOP_EVT3 <= 1'b0;
        rdchk(`ADDR_FLAGS, 8'h20, "top flag");
        @(posedge CLK) OVF_EVT1 <= 1'b1;
        OVF_EVT3 <= 1'b1;
        @(posedge CLK) OVF_EVT1 <= 1'b0;
        OVF_EVT3 <= 1'b0;
        rdchk(`ADDR_EXT_FLAGS, 8'h24, "ext flags");
        rdchk(`ADDR_FLAGS, 8'h24, "overflow flag");
    endtask
    initial begin
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        t_masks();
        t_compare();
        t_capture();
        t_top();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge CLK);
        failures++;
        end_sim();
    end
endmodule
